// *** core/pbpi_pkg.sv ***
`default_nettype none
package pbpi_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 24;
  localparam int IO_HI_LSB = 16;
  localparam logic [1:0] PHASE_RST = 2'h0;
  localparam int CLK_DIV = 2;
  typedef enum logic [2:0] {
    PBPI_MEM_RD = 3'b000,
    PBPI_MEM_WR = 3'b001,
    PBPI_IO_RD = 3'b010,
    PBPI_IO_WR = 3'b011,
    PBPI_INTA = 3'b100
  } pbpi_kind_e;
  typedef enum logic [1:0] {
    PBPI_SZ_WORD = 2'b00,
    PBPI_SZ_UPPER = 2'b01,
    PBPI_SZ_LOWER = 2'b10
  } pbpi_size_e;
  typedef enum logic [1:0] {
    PBPI_IDLE = 2'b00,
    PBPI_ADDR = 2'b01,
    PBPI_DATA = 2'b10
  } pbpi_state_e;
endpackage
`default_nettype wire

// *** core/pbpi_skid_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbpi_skid_buf #(
  parameter int WIDTH = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [1:0] count;
  logic [WIDTH-1:0] next_slot0;
  logic [WIDTH-1:0] next_slot1;
  logic [1:0] next_count;
  logic push;
  logic pop;

  assign inReady = (count != 2'h2);
  assign outValid = (count != 2'h0);
  assign outData = slot0;
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    next_slot0 = slot0;
    next_slot1 = slot1;
    next_count = count;
    if (pop) begin
      next_slot0 = slot1;
      next_count = next_count - 2'h1;
    end
    if (push) begin
      // write lands in the first free slot after any pop
      if (next_count == 2'h0) begin
        next_slot0 = inData;
      end else begin
        next_slot1 = inData;
      end
      next_count = next_count + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot0 <= '0;
      slot1 <= '0;
      count <= 2'h0;
    end else begin
      slot0 <= next_slot0;
      slot1 <= next_slot1;
      count <= next_count;
    end
  end
endmodule // pbpi_skid_buf
`default_nettype wire

// *** core/pbpi_bus_pins.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbpi_bus_pins #(
  parameter int DATA_W = pbpi_pkg::DATA_W,
  parameter int ADDR_W = pbpi_pkg::ADDR_W
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic resetPin,
  output logic procClkPhase,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [2:0] reqKind,
  input wire logic [1:0] reqSize,
  input wire logic [ADDR_W-1:0] reqAddr,
  input wire logic [DATA_W-1:0] reqWrData,
  output logic rspValid,
  input wire logic rspReady,
  output logic [DATA_W-1:0] rspData,
  input wire logic holdAck,
  output logic [ADDR_W-1:0] address_lines,
  output logic addrOe,
  output logic upper_byte_lane_enable_n,
  output logic byteEnOe,
  input wire logic [DATA_W-1:0] dataIn,
  output logic [DATA_W-1:0] dataOut,
  output logic dataOe,
  input wire logic busDone
);
  pbpi_pkg::pbpi_state_e state;
  pbpi_pkg::pbpi_state_e next_state;
  logic resetSync0;
  logic resetSync1;
  logic resetSync2;
  logic holdSync0;
  logic holdSync1;
  logic doneSync0;
  logic doneSync1;
  logic [DATA_W-1:0] dinSync0;
  logic [DATA_W-1:0] dinSync1;
  logic phase;
  logic next_phase;
  logic [ADDR_W-1:0] addrReg;
  logic [ADDR_W-1:0] next_addrReg;
  logic byteEnN;
  logic next_byteEnN;
  logic [DATA_W-1:0] wrData;
  logic [DATA_W-1:0] next_wrData;
  logic isWrite;
  logic next_isWrite;
  logic [DATA_W-1:0] capData;
  logic capValid;
  logic capReady;
  logic [ADDR_W-1:0] cycAddr;
  logic cycIo;
  logic cycWrite;
  logic cycByteEnN;
  logic [DATA_W-1:0] dataHeld;
  logic [DATA_W-1:0] next_dataHeld;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      resetSync0 <= 1'b0;
      resetSync1 <= 1'b0;
      resetSync2 <= 1'b0;
      holdSync0 <= 1'b0;
      holdSync1 <= 1'b0;
      doneSync0 <= 1'b0;
      doneSync1 <= 1'b0;
      dinSync0 <= '0;
      dinSync1 <= '0;
    end else begin
      resetSync0 <= resetPin;
      resetSync1 <= resetSync0;
      resetSync2 <= resetSync1;
      holdSync0 <= holdAck;
      holdSync1 <= holdSync0;
      doneSync0 <= busDone;
      doneSync1 <= doneSync0;
      dinSync0 <= dataIn;
      dinSync1 <= dinSync0;
    end
  end

  // halving toggle; a low-to-high on the reset pin forces a known phase
  always_comb begin
    next_phase = ~phase;
    if (resetSync1 && !resetSync2) begin
      next_phase = pbpi_pkg::PHASE_RST[0];
    end
  end
  assign procClkPhase = phase;

  // decode the request into pin values
  always_comb begin
    cycIo = (reqKind == pbpi_pkg::PBPI_IO_RD) || (reqKind == pbpi_pkg::PBPI_IO_WR);
    cycWrite = (reqKind == pbpi_pkg::PBPI_MEM_WR) || (reqKind == pbpi_pkg::PBPI_IO_WR);
    cycAddr = reqAddr;
    if (cycIo) begin
      cycAddr[ADDR_W-1:pbpi_pkg::IO_HI_LSB] = '0;
    end
    // word and lower-lane drive bit zero low, upper-lane drives it high
    if (reqSize == pbpi_pkg::PBPI_SZ_UPPER) begin
      cycAddr[0] = 1'b1;
    end else begin
      cycAddr[0] = 1'b0;
    end
    cycByteEnN = (reqSize == pbpi_pkg::PBPI_SZ_LOWER);
  end

  // only start when the bus is ours and the buffer can take the read word
  assign reqReady = (state == pbpi_pkg::PBPI_IDLE) && !holdSync1 && capReady;

  always_comb begin
    next_state = state;
    next_addrReg = addrReg;
    next_byteEnN = byteEnN;
    next_wrData = wrData;
    next_isWrite = isWrite;
    next_dataHeld = dataHeld;
    capValid = 1'b0;
    case (state)
      pbpi_pkg::PBPI_IDLE: begin
        if (reqValid && reqReady) begin
          next_addrReg = cycAddr;
          next_byteEnN = cycByteEnN;
          next_wrData = reqWrData;
          next_isWrite = cycWrite;
          next_state = pbpi_pkg::PBPI_ADDR;
        end
      end
      pbpi_pkg::PBPI_ADDR: begin
        if (isWrite) begin
          next_dataHeld = wrData;
        end
        next_state = pbpi_pkg::PBPI_DATA;
      end
      pbpi_pkg::PBPI_DATA: begin
        if (doneSync1) begin
          if (!isWrite) begin
            capValid = 1'b1;
            next_dataHeld = dinSync1;
          end
          next_state = pbpi_pkg::PBPI_IDLE;
        end
      end
      default: begin
        next_state = pbpi_pkg::PBPI_IDLE;
      end
    endcase
  end
  assign capData = dinSync1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      state <= pbpi_pkg::PBPI_IDLE;
      addrReg <= '0;
      byteEnN <= 1'b1;
      wrData <= '0;
      isWrite <= 1'b0;
      dataHeld <= '0;
    end else begin
      phase <= next_phase;
      state <= next_state;
      addrReg <= next_addrReg;
      byteEnN <= next_byteEnN;
      wrData <= next_wrData;
      isWrite <= next_isWrite;
      dataHeld <= next_dataHeld;
    end
  end

  // pin drivers; address and lane values stay put while floating, data holds the last word written or read so the bus keeps its last level
  assign address_lines = addrReg;
  assign addrOe = !holdSync1;
  assign upper_byte_lane_enable_n = byteEnN;
  assign byteEnOe = !holdSync1;
  assign dataOut = dataHeld;
  assign dataOe = !holdSync1 && isWrite && (state == pbpi_pkg::PBPI_DATA);

  // a stalled consumer cannot lose a read word: start is held off while full
  pbpi_skid_buf #(
    .WIDTH(DATA_W)
  ) u_rsp_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .inValid(capValid),
    .inReady(capReady),
    .inData(capData),
    .outValid(rspValid),
    .outReady(rspReady),
    .outData(rspData)
  );
endmodule // pbpi_bus_pins
`default_nettype wire

// *** dv/pbpi_bus_pins_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbpi_bus_pins_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic resetPin,
  input wire logic procClkPhase,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [2:0] reqKind,
  input wire logic [1:0] reqSize,
  input wire logic holdAck,
  input wire logic [23:0] address_lines,
  input wire logic addrOe,
  input wire logic upper_byte_lane_enable_n,
  input wire logic byteEnOe,
  input wire logic dataOe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic take;
  logic [1:0] laneQ;
  assign take = reqValid && reqReady;
  always_ff @(posedge core_clk) begin
    laneQ <= {reqSize == 2'h2, reqSize == 2'h1};
  end
  phase_toggle_a: assert property (!resetPin [*5] |-> procClkPhase != $past(procClkPhase))
    else $error("phase did not toggle");
  phase_align_a: assert property ($rose(resetPin) |-> ##[2:4] !procClkPhase)
    else $error("phase not aligned");
  io_high_a: assert property (take && reqKind inside {3'h2, 3'h3} |=> address_lines[23:16] == 8'h00)
    else $error("io upper address not low");
  lane_code_a: assert property (take |=> {upper_byte_lane_enable_n, address_lines[0]} == laneQ)
    else $error("lane code wrong");
  hold_float_a: assert property (holdAck [*4] |-> !addrOe && !byteEnOe && !dataOe)
    else $error("driving during hold");
  hold_end_a: assert property (!holdAck [*4] |-> addrOe && byteEnOe)
    else $error("address not driven");
  read_quiet_a: assert property (take && !reqKind[0] |=> !dataOe [*3])
    else $error("data driven in read");
  busy_refuse_a: assert property (take |=> !reqReady)
    else $error("request taken while busy");
endmodule // pbpi_bus_pins_checker
bind pbpi_bus_pins pbpi_bus_pins_checker i_pbpi_bus_pins_checker (.*);
`default_nettype wire

// *** dv/pbpi_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbpi_far_side (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reqReady,
  input wire logic holdAck,
  input wire logic dataOe,
  input wire logic [15:0] dataOut,
  input wire logic [23:0] address_lines,
  input wire logic upper_byte_lane_enable_n,
  input wire logic [3:0] lat,
  output logic busDone,
  output logic [15:0] dataIn
);
  logic [15:0] mem;
  logic [3:0] cnt;
  assign dataIn = dataOe ? dataOut : mem;
  // done is a one-cycle pulse, so its synchronised copy never ends the next cycle early
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      busDone <= 1'b0;
      mem <= 16'h0000;
    end else begin
      busDone <= 1'b0;
      // each byte lane's select is qualified by its own enable
      if (dataOe && busDone && !upper_byte_lane_enable_n) mem[15:8] <= dataOut[15:8];
      if (dataOe && busDone && !address_lines[0]) mem[7:0] <= dataOut[7:0];
      if (reqReady || holdAck) begin
        cnt <= 4'h0;
      end else if (cnt == lat) begin
        busDone <= 1'b1;
        cnt <= cnt + 4'h1;
      end else if (cnt < lat) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule // pbpi_far_side
`default_nettype wire

// *** dv/pbpi_bus_pins_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module pbpi_bus_pins_bench;
  logic core_clk = 0, rst_n = 0, resetPin = 0, reqValid = 0, rspReady = 1, holdAck = 0;
  logic [2:0] reqKind = 0;
  logic [1:0] reqSize = 0;
  logic [23:0] reqAddr = 0, address_lines;
  logic [15:0] reqWrData = 0, rspData, dataIn, dataOut;
  logic procClkPhase, reqReady, rspValid, addrOe, upper_byte_lane_enable_n, byteEnOe, dataOe;
  logic busDone;
  logic [3:0] lat = 4'h2;
  int miscompares = 0, check_count = 0, cyc = 0;
  pbpi_bus_pins i_pbpi_bus_pins (.*);
  pbpi_far_side i_pbpi_far_side (.*);
  initial forever #20 core_clk = ~core_clk;
  task end_sim;
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic [2:0] k, input logic [1:0] s, input logic [23:0] a,
                      input logic [15:0] d);
    int n = 0;
    @(negedge core_clk);
    while (reqReady !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    reqKind = k;
    reqSize = s;
    reqAddr = a;
    reqWrData = d;
    reqValid = 1;
    @(negedge core_clk);
    reqValid = 0;
    @(negedge core_clk);
  endtask
  task automatic rd(input logic [15:0] e);
    int n = 0;
    while (rspValid !== 1'b1 && n < 300) begin
      @(negedge core_clk);
      n++;
    end
    chk({7'h00, rspValid, rspData}, {8'h01, e});
    @(negedge core_clk);
  endtask
  task s_word;
    xfer(pbpi_pkg::PBPI_MEM_WR, 2'h0, 24'hFFFFFE, 16'hA5C3);
    chk(address_lines, 24'hFFFFFE);
    xfer(pbpi_pkg::PBPI_MEM_RD, 2'h0, 24'hFFFFFE, 16'h0000);
    rd(16'hA5C3);
  endtask
  task s_io;
    xfer(pbpi_pkg::PBPI_IO_WR, 2'h0, 24'hAB1234, 16'h1357);
    chk(address_lines, 24'h001234);
    xfer(pbpi_pkg::PBPI_IO_RD, 2'h0, 24'hCD1234, 16'h0000);
    chk(address_lines, 24'h001234);
    rd(16'h1357);
  endtask
  task s_lane;
    for (int i = 0; i < 4; i++) begin
      xfer(pbpi_pkg::PBPI_MEM_WR, i[1:0], 24'h000101, 16'h2468);
      chk({22'h0, upper_byte_lane_enable_n, address_lines[0]}, {22'h0, i == 2, i == 1});
    end
    xfer(pbpi_pkg::PBPI_INTA, 2'h0, 24'h000000, 16'h0000);
    rd(16'h2468);
  endtask
  task s_hold;
    @(negedge core_clk);
    holdAck = 1;
    repeat (6) @(negedge core_clk);
    chk({20'h0, addrOe, byteEnOe, dataOe, reqReady}, 24'h0);
    holdAck = 0;
    repeat (6) @(negedge core_clk);
    chk({22'h0, addrOe, byteEnOe}, 24'h3);
  endtask
  task s_phase;
    logic p;
    resetPin = 1;
    repeat (6) @(negedge core_clk);
    chk({23'h0, procClkPhase}, 24'h1);
    resetPin = 0;
    repeat (6) @(negedge core_clk);
    p = procClkPhase;
    @(negedge core_clk);
    chk({23'h0, procClkPhase}, {23'h0, ~p});
  endtask
  // receiver stalls with a slow bus: two words wait, the third request must be held off
  task s_buf;
    rspReady = 0;
    lat = 4'h6;
    xfer(pbpi_pkg::PBPI_MEM_RD, 2'h0, 24'h000200, 16'h0000);
    xfer(pbpi_pkg::PBPI_MEM_RD, 2'h2, 24'h000200, 16'h0000);
    repeat (30) @(negedge core_clk);
    chk({23'h0, reqReady}, 24'h0);
    rspReady = 1;
    rd(16'h2468);
    rd(16'h2468);
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1;
    s_word();
    s_io();
    s_lane();
    s_hold();
    s_phase();
    s_buf();
    end_sim();
  end
endmodule // pbpi_bus_pins_bench
`default_nettype wire
